// File: verilog/uie_pkg.sv
// Package: register map, field positions and reset values of the USB interrupt enable block
package uie_pkg;

   // ********************************************************
   // Register offsets (byte addresses)
   // ********************************************************
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  OFF_INT_ENABLES   = 8'h00;
   localparam logic [7:0]  OFF_EVENT_STATUS  = 8'h04;
   localparam logic [7:0]  OFF_IRQ_MASK      = 8'h08;
   localparam logic [7:0]  OFF_MODE_CTRL     = 8'h0c;
   localparam logic [7:0]  OFF_RAW_FLAGS     = 8'h10;

   // ********************************************************
   // Field positions of the enable / flag layout
   // ********************************************************
   localparam int          NUM_EVENTS        = 8;
   localparam int          BIT_STALL         = 7;
   localparam int          BIT_ATTACH        = 6;
   localparam int          BIT_RESUME        = 5;
   localparam int          BIT_IDLE          = 4;
   localparam int          BIT_TOKEN_DONE    = 3;
   localparam int          BIT_FRAME_START   = 2;
   localparam int          BIT_BUS_ERROR     = 1;
   localparam int          BIT_RESET_DETACH  = 0;
   localparam int          BIT_HOST_MODE     = 0;

   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [7:0]  RST_INT_ENABLES   = 8'h00;
   localparam logic [7:0]  RST_EVENT_STATUS  = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK      = 8'h00;
   localparam logic [31:0] RD_UNMAPPED       = 32'h0000_0000;

   typedef enum logic [0:0] {
      UIE_MODE_DEVICE = 1'b0,
      UIE_MODE_HOST   = 1'b1
   } uie_mode_type;

endpackage : uie_pkg

// File: verilog/uie_usb_int_enable.sv
// Module: USB interrupt enable mask with sticky status, mask and combined interrupt
`timescale 1ns/10ps
// What this block does
// RQ1: Stall event interrupts only while enable bit 7 is one.
// RQ2: Attach event interrupts only while enable bit 6 is one.
// RQ3: Resume event interrupts only while enable bit 5 is one.
// RQ4: Idle-detect event interrupts only while enable bit 4 is one.
// RQ5: Token-complete flag interrupts only while enable bit 3 is one.
// RQ6: Frame-start flag interrupts only while enable bit 2 is one.
// RQ7: Bus error interrupts only while enable bit 1 is one.
// RQ8: Device mode: bit 0 enables the bus-reset flag interrupt.
// RQ9: Host mode: bit 0 enables the detach flag interrupt.
// RQ10: Error events reach the combined flag only with enable bit 1 set.
// RQ11: Enable bits 31 to 8 read zero and ignore writes.
// RQ12: Reset clears all eight enable bits.
module uie_usb_int_enable
   import uie_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                      clock_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      clk_en_i,
   // Register port
   input  wire logic [uie_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   // USB event flags, same clock
   input  wire logic                      stall_event_i,
   input  wire logic                      attach_event_i,
   input  wire logic                      resume_event_i,
   input  wire logic                      idle_event_i,
   input  wire logic                      token_complete_flag_i,
   input  wire logic                      frame_start_flag_i,
   input  wire logic                      bus_error_event_i,
   input  wire logic                      bus_reset_flag_i,
   input  wire logic                      detach_flag_i,
   // Interrupt outputs
   output logic                           combined_usb_irq_flag_o,
   output logic                           irq_o
);
   import uie_pkg::*;

   // ********************************************************
   // Storage
   // ********************************************************
   logic [NUM_EVENTS-1:0] usb_interrupt_enables_q;
   logic [NUM_EVENTS-1:0] event_status_q;
   logic [NUM_EVENTS-1:0] irq_mask_q;
   uie_mode_type          mode_q;
   logic [NUM_EVENTS-1:0] raw_flags;
   logic [NUM_EVENTS-1:0] gated_d;
   logic [NUM_EVENTS-1:0] status_d;
   logic [31:0]           rdata_d;
   logic [NUM_EVENTS-1:0] status_clr;
   logic [NUM_EVENTS-1:0] pending;
   logic                  wr_en;

   assign wr_en = reg_wr_i & clk_en_i;

   // ********************************************************
   // Event gathering, bit 0 source select and status clear decode
   // ********************************************************
   always_comb begin
      raw_flags                   = '0;
      raw_flags[BIT_STALL]        = stall_event_i;
      raw_flags[BIT_ATTACH]       = attach_event_i;
      raw_flags[BIT_RESUME]       = resume_event_i;
      raw_flags[BIT_IDLE]         = idle_event_i;
      raw_flags[BIT_TOKEN_DONE]   = token_complete_flag_i;
      raw_flags[BIT_FRAME_START]  = frame_start_flag_i;
      raw_flags[BIT_BUS_ERROR]    = bus_error_event_i;
      // Shared bit 0 picks its source from the mode
      if (mode_q == UIE_MODE_HOST) begin
         raw_flags[BIT_RESET_DETACH] = detach_flag_i; // RQ9
      end else begin
         raw_flags[BIT_RESET_DETACH] = bus_reset_flag_i; // RQ8
      end
   end

   // Write one to clear; only the low eight bits carry status
   always_comb begin
      status_clr = '0;
      if (wr_en && reg_addr_i == OFF_EVENT_STATUS) begin
         status_clr = reg_wdata_i[NUM_EVENTS-1:0];
      end
   end

   // ********************************************************
   // Event lanes: gate, sticky status and request per bit
   // ********************************************************
   uie_event_lane lane_stall_u (
      .raw_i     (raw_flags[BIT_STALL]),
      .enable_i  (usb_interrupt_enables_q[BIT_STALL]), // RQ1
      .mask_i    (irq_mask_q[BIT_STALL]),
      .status_i  (event_status_q[BIT_STALL]),
      .clear_i   (status_clr[BIT_STALL]),
      .gated_o   (gated_d[BIT_STALL]),
      .status_o  (status_d[BIT_STALL]),
      .pending_o (pending[BIT_STALL])
   );

   uie_event_lane lane_attach_u (
      .raw_i     (raw_flags[BIT_ATTACH]),
      .enable_i  (usb_interrupt_enables_q[BIT_ATTACH]), // RQ2
      .mask_i    (irq_mask_q[BIT_ATTACH]),
      .status_i  (event_status_q[BIT_ATTACH]),
      .clear_i   (status_clr[BIT_ATTACH]),
      .gated_o   (gated_d[BIT_ATTACH]),
      .status_o  (status_d[BIT_ATTACH]),
      .pending_o (pending[BIT_ATTACH])
   );

   uie_event_lane lane_resume_u (
      .raw_i     (raw_flags[BIT_RESUME]),
      .enable_i  (usb_interrupt_enables_q[BIT_RESUME]), // RQ3
      .mask_i    (irq_mask_q[BIT_RESUME]),
      .status_i  (event_status_q[BIT_RESUME]),
      .clear_i   (status_clr[BIT_RESUME]),
      .gated_o   (gated_d[BIT_RESUME]),
      .status_o  (status_d[BIT_RESUME]),
      .pending_o (pending[BIT_RESUME])
   );

   uie_event_lane lane_idle_u (
      .raw_i     (raw_flags[BIT_IDLE]),
      .enable_i  (usb_interrupt_enables_q[BIT_IDLE]), // RQ4
      .mask_i    (irq_mask_q[BIT_IDLE]),
      .status_i  (event_status_q[BIT_IDLE]),
      .clear_i   (status_clr[BIT_IDLE]),
      .gated_o   (gated_d[BIT_IDLE]),
      .status_o  (status_d[BIT_IDLE]),
      .pending_o (pending[BIT_IDLE])
   );

   uie_event_lane lane_token_u (
      .raw_i     (raw_flags[BIT_TOKEN_DONE]),
      .enable_i  (usb_interrupt_enables_q[BIT_TOKEN_DONE]), // RQ5
      .mask_i    (irq_mask_q[BIT_TOKEN_DONE]),
      .status_i  (event_status_q[BIT_TOKEN_DONE]),
      .clear_i   (status_clr[BIT_TOKEN_DONE]),
      .gated_o   (gated_d[BIT_TOKEN_DONE]),
      .status_o  (status_d[BIT_TOKEN_DONE]),
      .pending_o (pending[BIT_TOKEN_DONE])
   );

   uie_event_lane lane_frame_u (
      .raw_i     (raw_flags[BIT_FRAME_START]),
      .enable_i  (usb_interrupt_enables_q[BIT_FRAME_START]), // RQ6
      .mask_i    (irq_mask_q[BIT_FRAME_START]),
      .status_i  (event_status_q[BIT_FRAME_START]),
      .clear_i   (status_clr[BIT_FRAME_START]),
      .gated_o   (gated_d[BIT_FRAME_START]),
      .status_o  (status_d[BIT_FRAME_START]),
      .pending_o (pending[BIT_FRAME_START])
   );

   uie_event_lane lane_error_u (
      .raw_i     (raw_flags[BIT_BUS_ERROR]),
      .enable_i  (usb_interrupt_enables_q[BIT_BUS_ERROR]), // RQ7 RQ10
      .mask_i    (irq_mask_q[BIT_BUS_ERROR]),
      .status_i  (event_status_q[BIT_BUS_ERROR]),
      .clear_i   (status_clr[BIT_BUS_ERROR]),
      .gated_o   (gated_d[BIT_BUS_ERROR]),
      .status_o  (status_d[BIT_BUS_ERROR]),
      .pending_o (pending[BIT_BUS_ERROR])
   );

   uie_event_lane lane_shared_u (
      .raw_i     (raw_flags[BIT_RESET_DETACH]),
      .enable_i  (usb_interrupt_enables_q[BIT_RESET_DETACH]), // RQ8 RQ9
      .mask_i    (irq_mask_q[BIT_RESET_DETACH]),
      .status_i  (event_status_q[BIT_RESET_DETACH]),
      .clear_i   (status_clr[BIT_RESET_DETACH]),
      .gated_o   (gated_d[BIT_RESET_DETACH]),
      .status_o  (status_d[BIT_RESET_DETACH]),
      .pending_o (pending[BIT_RESET_DETACH])
   );

   // ********************************************************
   // Enable register
   // ********************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         usb_interrupt_enables_q <= RST_INT_ENABLES; // RQ12
      end else if (wr_en && reg_addr_i == OFF_INT_ENABLES) begin
         // Upper bits of the write are dropped
         usb_interrupt_enables_q <= reg_wdata_i[NUM_EVENTS-1:0]; // RQ11
      end
   end

   // ********************************************************
   // Mode and mask registers
   // ********************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= UIE_MODE_DEVICE;
      end else if (wr_en && reg_addr_i == OFF_MODE_CTRL) begin
         mode_q <= uie_mode_type'(reg_wdata_i[BIT_HOST_MODE]);
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_q <= RST_IRQ_MASK;
      end else if (wr_en && reg_addr_i == OFF_IRQ_MASK) begin
         irq_mask_q <= reg_wdata_i[NUM_EVENTS-1:0];
      end
   end

   // ********************************************************
   // Sticky status, write one to clear
   // ********************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_status_q <= RST_EVENT_STATUS;
      end else if (clk_en_i) begin
         event_status_q <= status_d;
      end
   end

   // ********************************************************
   // Interrupt outputs, registered
   // ********************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         combined_usb_irq_flag_o <= 1'b0;
         irq_o                   <= 1'b0;
      end else if (clk_en_i) begin
         combined_usb_irq_flag_o <= |gated_d; // RQ10
         irq_o                   <= |pending;
      end
   end

   // ********************************************************
   // Read port
   // ********************************************************
   always_comb begin
      rdata_d = RD_UNMAPPED;
      case (reg_addr_i)
         OFF_INT_ENABLES:  rdata_d[NUM_EVENTS-1:0] = usb_interrupt_enables_q; // RQ11
         OFF_EVENT_STATUS: rdata_d[NUM_EVENTS-1:0] = event_status_q;
         OFF_IRQ_MASK:     rdata_d[NUM_EVENTS-1:0] = irq_mask_q;
         OFF_MODE_CTRL:    rdata_d[BIT_HOST_MODE]  = mode_q;
         OFF_RAW_FLAGS:    rdata_d[NUM_EVENTS-1:0] = raw_flags;
         default:          rdata_d = RD_UNMAPPED;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= RD_UNMAPPED;
      end else if (clk_en_i) begin
         reg_rdata_o <= reg_rd_i ? rdata_d : RD_UNMAPPED;
      end
   end

endmodule : uie_usb_int_enable

// ********************************************************
// One event lane: enable gate, sticky status, request
// ********************************************************
module uie_event_lane (
   // Event and its controls
   input  wire logic raw_i,
   input  wire logic enable_i,
   input  wire logic mask_i,
   input  wire logic status_i,
   input  wire logic clear_i,
   // Gated event, next status, request of this lane
   output logic      gated_o,
   output logic      status_o,
   output logic      pending_o
);
   always_comb begin
      gated_o   = raw_i & enable_i;
      // Set after clear so a coincident event is kept
      status_o  = (status_i & ~clear_i) | gated_o;
      pending_o = status_o & mask_i;
   end
endmodule : uie_event_lane

// File: sim/uie_assertions.sv
// Checker: gating of USB events into the combined flag, enable readback
`timescale 1ns/10ps
module uie_assertions
   import uie_pkg::*;
(
   input wire logic                       clock_i,
   input wire logic                       rst_n_i,
   input wire logic                       clk_en_i,
   input wire logic [uie_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0]                reg_wdata_i,
   input wire logic                       reg_wr_i,
   input wire logic                       reg_rd_i,
   input wire logic [31:0]                reg_rdata_o,
   input wire logic stall_event_i, attach_event_i, resume_event_i, idle_event_i,
   input wire logic token_complete_flag_i, frame_start_flag_i, bus_error_event_i,
   input wire logic bus_reset_flag_i, detach_flag_i, combined_usb_irq_flag_o, irq_o
);
   logic [7:0] en_q;
   logic       host_q;
   logic [7:0] raw;
   // ********************************************************
   // Shadow of enables and mode, so gating is judged per bit
   // ********************************************************
   assign raw = {stall_event_i, attach_event_i, resume_event_i, idle_event_i,
                 token_complete_flag_i, frame_start_flag_i, bus_error_event_i,
                 host_q ? detach_flag_i : bus_reset_flag_i} & en_q;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q   <= 8'h00;
         host_q <= 1'b0;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == OFF_INT_ENABLES) en_q <= reg_wdata_i[7:0];
         if (reg_addr_i == OFF_MODE_CTRL) host_q <= reg_wdata_i[0];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_pass(logic b);
      clk_en_i && b |=> combined_usb_irq_flag_o;
   endproperty
   chk_stall_pass: assert property (p_pass(raw[7])) else $error("stall gate");
   chk_attach_pass: assert property (p_pass(raw[6])) else $error("attach gate");
   chk_resume_pass: assert property (p_pass(raw[5])) else $error("resume gate");
   chk_idle_pass: assert property (p_pass(raw[4])) else $error("idle gate");
   chk_token_pass: assert property (p_pass(raw[3])) else $error("token gate");
   chk_frame_pass: assert property (p_pass(raw[2])) else $error("frame gate");
   chk_error_pass: assert property (p_pass(raw[1])) else $error("error gate");
   chk_reset_pass: assert property (p_pass(raw[0] && !host_q)) else $error("reset gate");
   chk_detach_pass: assert property (p_pass(raw[0] && host_q)) else $error("detach gate");
   chk_all_masked: assert property (clk_en_i && raw == 8'h00
      |=> !combined_usb_irq_flag_o) else $error("masked event passed");
   chk_enable_readback: assert property (clk_en_i && reg_rd_i
      && reg_addr_i == OFF_INT_ENABLES |=> reg_rdata_o == {24'h0, en_q})
      else $error("enable readback");
   cover property (clk_en_i && raw[0] && host_q);
   cover property (clk_en_i && raw[1]);
   cover property ($rose(irq_o));
endmodule : uie_assertions

// File: sim/uie_event_src.sv
// Model of the USB event flag logic feeding the enable block
`timescale 1ns/10ps
module uie_event_src (
   // Clock, reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // Control from the bench
   input  wire logic       hold_i,
   input  wire logic [8:0] pattern_i,
   // Flags: detach, stall down to error, bus reset
   output logic      [8:0] events_o
);
   int seed = 32'h695f;
   // Random flags only while the bench lets go, so directed steps stay exact
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) events_o <= 9'h000;
      else if (hold_i) events_o <= pattern_i;
      else events_o <= 9'($random(seed));
   end
endmodule : uie_event_src

// File: sim/tb_usb_interrupt_enable_mask.sv
// Self-checking bench for the USB interrupt enable block
`timescale 1ns/10ps
module tb_usb_interrupt_enable_mask;
   import uie_pkg::*;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic        hold = 1'b1, rd_d = 1'b0, irq_o, comb, clk_en = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic [8:0]  pattern = 9'h000, ev;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0, samples_checked = 0;
   initial forever #2 clock_i = ~clock_i;
   uie_event_src partner_u (.clock_i, .rst_n_i, .hold_i(hold), .pattern_i(pattern), .events_o(ev));
   uie_usb_int_enable dut_u (.clock_i, .rst_n_i, .clk_en_i(clk_en), .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .stall_event_i(ev[7]), .attach_event_i(ev[6]),
      .resume_event_i(ev[5]), .idle_event_i(ev[4]), .token_complete_flag_i(ev[3]),
      .frame_start_flag_i(ev[2]), .bus_error_event_i(ev[1]), .bus_reset_flag_i(ev[0]),
      .detach_flag_i(ev[8]), .combined_usb_irq_flag_o(comb), .irq_o);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(posedge clock_i);
   endtask : rd
   task automatic pulse(input logic [8:0] p);
      pattern <= p;
      @(posedge clock_i);
      pattern <= 9'h000;
      repeat (2) @(posedge clock_i);
   endtask : pulse
   task automatic ichk(input logic e);
      @(negedge clock_i);
      chk("irq", 32'(e), 32'(irq_o));
      @(posedge clock_i);
   endtask : ichk
   // ********************************************************
   // Read data scoreboard: answer stands only the cycle after the strobe
   // ********************************************************
   always @(posedge clock_i) begin
      if (rd_d) chk("rdata", exp_q.pop_front(), reg_rdata_o);
      rd_d <= reg_rd_i;
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rd(OFF_INT_ENABLES, 32'h0);
      wr(OFF_INT_ENABLES, 32'hffff_ffff);
      rd(OFF_INT_ENABLES, 32'h0000_00ff);
      rd(8'h14, 32'h0);
      wr(OFF_IRQ_MASK, 32'hff);
      for (int m = 0; m < 2; m++) begin
         wr(OFF_MODE_CTRL, 32'(m));
         for (int i = 0; i < 9; i++) begin
            int b;
            logic [31:0] e;
            b = (i == 8) ? 0 : i;
            e = ((i == 8 && m == 1) || (i == 0 && m == 0) || (i > 0 && i < 8)) ? 32'h1 << b : 0;
            wr(OFF_INT_ENABLES, ~(32'h1 << b) & 32'hff);
            pulse(9'h1 << i);
            rd(OFF_EVENT_STATUS, 32'h0);
            ichk(1'b0);
            wr(OFF_INT_ENABLES, 32'h1 << b);
            pulse(9'h1 << i);
            rd(OFF_EVENT_STATUS, e);
            ichk(e != 0);
            wr(OFF_EVENT_STATUS, 32'hff);
         end
         wr(OFF_INT_ENABLES, 32'h5a);
         hold <= 1'b0;
         repeat (300) @(posedge clock_i);
         hold <= 1'b1;
         // Last random flags land one edge later; clear only after them
         repeat (2) @(posedge clock_i);
         wr(OFF_EVENT_STATUS, 32'hff);
      end
      // Write while frozen must not land
      clk_en <= 1'b0;
      wr(OFF_INT_ENABLES, 32'h0);
      clk_en <= 1'b1;
      rd(OFF_INT_ENABLES, 32'h5a);
      wr(OFF_IRQ_MASK, 32'h0);
      pulse(9'h002);
      rd(OFF_EVENT_STATUS, 32'h2);
      ichk(1'b0);
      wr(OFF_IRQ_MASK, 32'h2);
      ichk(1'b1);
      close_out();
   end
endmodule : tb_usb_interrupt_enable_mask
bind uie_usb_int_enable uie_assertions chk_u (.clock_i, .rst_n_i, .clk_en_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .stall_event_i, .attach_event_i,
   .resume_event_i, .idle_event_i, .token_complete_flag_i, .frame_start_flag_i,
   .bus_error_event_i, .bus_reset_flag_i, .detach_flag_i, .combined_usb_irq_flag_o, .irq_o);
